// ===== ulde_pkg.sv
// Shared constants and carrier types for the link and DRAM event selector.
// Assumes a single uncore clock domain and that all event sources are
// produced by logic on that same clock.
package ulde_pkg;

    // Register offsets on the plain software port (byte addresses)
    localparam logic [7:0] ULDE_ADDR_SEL = 8'h00;
    localparam logic [7:0] ULDE_ADDR_STATUS = 8'h04;
    localparam logic [7:0] ULDE_ADDR_COND = 8'h08;

    // Field positions inside the selector register
    localparam int ULDE_SEL_CODE_LSB = 0;
    localparam int ULDE_SEL_MASK_LSB = 8;

    // Values after reset
    localparam logic [7:0] ULDE_RST_CODE = 8'h00;
    localparam logic [7:0] ULDE_RST_MASK = 8'h00;
    localparam logic [31:0] ULDE_RST_RDATA = 32'h0000_0000;

    // Event codes
    localparam logic [7:0] ULDE_EV_TX_MULTI = 8'h41;
    localparam logic [7:0] ULDE_EV_HDR_BUSY = 8'h42;
    localparam logic [7:0] ULDE_EV_SNP_STALL = 8'h43;
    localparam logic [7:0] ULDE_EV_PAGE_OPEN = 8'h60;
    localparam logic [7:0] ULDE_EV_IDLE_CLOSE = 8'h61;
    localparam logic [7:0] ULDE_EV_PAGE_MISS = 8'h62;

    // Unit masks for multi-flit credit stalls
    localparam logic [7:0] ULDE_UM_L0_DRS = 8'h01;
    localparam logic [7:0] ULDE_UM_L0_NCB = 8'h02;
    localparam logic [7:0] ULDE_UM_L0_NCS = 8'h04;
    localparam logic [7:0] ULDE_UM_L1_DRS = 8'h08;
    localparam logic [7:0] ULDE_UM_L1_NCB = 8'h10;
    localparam logic [7:0] ULDE_UM_L1_NCS = 8'h20;
    localparam logic [7:0] ULDE_UM_L0_ALL = 8'h07;
    localparam logic [7:0] ULDE_UM_L1_ALL = 8'h38;

    // Unit masks for header busy, snoop stall and DRAM channels
    localparam logic [7:0] ULDE_UM_HDR_L0 = 8'h02;
    localparam logic [7:0] ULDE_UM_HDR_L1 = 8'h08;
    localparam logic [7:0] ULDE_UM_LINK0 = 8'h01;
    localparam logic [7:0] ULDE_UM_LINK1 = 8'h02;
    localparam logic [7:0] ULDE_UM_CH0 = 8'h01;
    localparam logic [7:0] ULDE_UM_CH1 = 8'h02;
    localparam logic [7:0] ULDE_UM_CH2 = 8'h04;

    // DRAM command geometry
    localparam int ULDE_BANK_W = 3;
    localparam int ULDE_ROW_W = 16;

    // DRAM command kinds seen from a channel scheduler
    typedef enum logic [1:0] {
        ULDE_CMD_OTHER = 2'h0,
        ULDE_CMD_ACT = 2'h1,
        ULDE_CMD_PRE = 2'h2
    } ulde_cmd_kind_t;

    // One multi-flit virtual channel: pending flit and credit levels
    typedef struct packed {
        logic flit_pending;
        logic shared_credit_pool_avail;
        logic dedicated_credit_pool_avail;
    } ulde_vc_t;

    // Everything one link reports per cycle
    typedef struct packed {
        ulde_vc_t data_response_channel;
        ulde_vc_t noncoherent_bypass_channel;
        ulde_vc_t noncoherent_standard_channel;
        logic hdr_buffer_busy;
        logic snoop_pending;
        logic peer_probe_tracker_full;
    } ulde_link_t;

    // One command issued by a channel scheduler
    typedef struct packed {
        logic valid;
        ulde_cmd_kind_t kind;
        logic [ULDE_BANK_W-1:0] bank;
        logic [ULDE_ROW_W-1:0] row;
        logic idle_expired;
    } ulde_dram_cmd_t;

    // Classified DRAM events of one channel
    typedef struct packed {
        logic page_open;
        logic idle_close;
        logic page_miss;
    } ulde_dram_evt_t;

endpackage

// ===== ulde_dram_track.sv
// Per-channel DRAM command classifier with an open-page table per bank.
// Assumes the scheduler issues at most one command per cycle on this
// channel, on the same clock.
`timescale 1ns/1ps

module ulde_dram_track #(
    parameter int BANKS = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire ulde_pkg::ulde_dram_cmd_t cmd,
    output ulde_pkg::ulde_dram_evt_t evt
);

    // Open-page table: valid flag and open row per bank
    logic [BANKS-1:0] open_vld_r;
    logic [BANKS-1:0] open_vld_nxt;
    logic [ulde_pkg::ULDE_ROW_W-1:0] open_row_r [BANKS];
    logic [ulde_pkg::ULDE_ROW_W-1:0] open_row_nxt [BANKS];

    // Command kinds decoded once
    logic is_act;
    logic is_pre;
    logic bank_open;

    assign is_act = cmd.valid && (cmd.kind == ulde_pkg::ULDE_CMD_ACT);
    assign is_pre = cmd.valid && (cmd.kind == ulde_pkg::ULDE_CMD_PRE);
    assign bank_open = open_vld_r[cmd.bank];

    // Classification, purely combinational; the top registers the result
    always_comb
    begin
        evt.page_open = is_act;
        // Idle timer closes take priority over miss attribution
        evt.idle_close = is_pre && cmd.idle_expired;
        // Miss: bank holds a page and a different row is wanted
        evt.page_miss = is_pre && !cmd.idle_expired && bank_open
            && (open_row_r[cmd.bank] != cmd.row);
    end

    // Table next state: activate opens, precharge closes
    always_comb
    begin
        open_vld_nxt = open_vld_r;
        open_row_nxt = open_row_r;
        if (is_act)
        begin
            open_vld_nxt[cmd.bank] = 1'b1;
            open_row_nxt[cmd.bank] = cmd.row;
        end
        else if (is_pre)
        begin
            open_vld_nxt[cmd.bank] = 1'b0;
        end
    end

    // Table registers; rows need no reset since valid guards them
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            open_vld_r <= '0;
        end
        else
        begin
            open_vld_r <= open_vld_nxt;
        end
        open_row_r <= open_row_nxt;
    end

endmodule // ulde_dram_track

// ===== ulde_event_select.sv
// Event selector for off-core link and DRAM performance events.
// Assumes every event source runs on mclk and that software programs the
// selector over the plain register port before reading results.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps

// How it works
// - Code 41H mask 08H: link1 data-response credit stall
// - Code 41H mask 10H: link1 bypass credit stall
// - Code 41H mask 20H: link1 standard credit stall
// - Code 41H mask 07H: any link0 channel stalled
// - Code 41H mask 38H: any link1 channel stalled
// - Stall counting ignores arbitration losses entirely
// - Code 42H mask 02H: link0 header buffer busy
// - Code 42H mask 08H: link1 header buffer busy
// - Code 43H: snoop held, tracker full, per link
// - Code 60H: page opens per channel mask
// - Activation before access to closed page counts
// - Code 61H: idle timer precharges per channel
// - Code 62H: page miss precharges per channel
// - Miss: open bank, different row wanted
// - Code 41H mask 01H: link0 data-response stall

module ulde_event_select #(
    parameter int CHANNELS = 3,
    parameter int BANKS = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire ulde_pkg::ulde_link_t link0,
    input wire ulde_pkg::ulde_link_t link1,
    input wire ulde_pkg::ulde_dram_cmd_t dram_cmd [CHANNELS],
    output logic inc
);

    // Credit stall: flit waiting and neither pool has a credit.
    // Grants to other channels are deliberately not looked at.
    function automatic logic vc_stall(input ulde_pkg::ulde_vc_t vc);
        vc_stall = vc.flit_pending && !vc.shared_credit_pool_avail
            && !vc.dedicated_credit_pool_avail;
    endfunction

    // Byte field of the selector word, picked by its low bit position
    function automatic logic [7:0] sel_field(input logic [31:0] w, input int lsb);
        sel_field = w[lsb +: 8];
    endfunction

    // Programmed event code and unit mask
    logic [7:0] code_r;
    logic [7:0] code_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;

    // Registered increment and match flag
    logic inc_r;
    logic inc_nxt;
    logic match_r;
    logic match_nxt;

    // Registered read data, valid only in the cycle after a read
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // Per-channel classified DRAM events
    ulde_pkg::ulde_dram_evt_t dram_evt [CHANNELS];
    logic [CHANNELS-1:0] ch_open;
    logic [CHANNELS-1:0] ch_close;
    logic [CHANNELS-1:0] ch_miss;

    // Per-link stall conditions, bit 0 data response, 1 bypass, 2 standard
    logic [2:0] l0_stall;
    logic [2:0] l1_stall;
    logic l0_snoop_stall;
    logic l1_snoop_stall;

    // Current decoded condition and whether the pair is defined
    logic cond;
    logic defined;

    // One classifier per DRAM channel
    // Decode assumes CHANNELS is 3
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_chan
            ulde_dram_track #(
                .BANKS(BANKS)
            ) u_track (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .cmd(dram_cmd[gi]),
                .evt(dram_evt[gi])
            );
            assign ch_open[gi] = dram_evt[gi].page_open;
            assign ch_close[gi] = dram_evt[gi].idle_close;
            assign ch_miss[gi] = dram_evt[gi].page_miss;
        end
    endgenerate

    // Link stall conditions for both links
    // Aggregates OR these, one count per cycle
    always_comb
    begin
        l0_stall[0] = vc_stall(link0.data_response_channel);
        l0_stall[1] = vc_stall(link0.noncoherent_bypass_channel);
        l0_stall[2] = vc_stall(link0.noncoherent_standard_channel);
        l1_stall[0] = vc_stall(link1.data_response_channel);
        l1_stall[1] = vc_stall(link1.noncoherent_bypass_channel);
        l1_stall[2] = vc_stall(link1.noncoherent_standard_channel);
        // Snoop held only while a snoop actually waits on a full tracker
        l0_snoop_stall = link0.snoop_pending && link0.peer_probe_tracker_full;
        l1_snoop_stall = link1.snoop_pending && link1.peer_probe_tracker_full;
    end

    // Event decode from programmed code and mask
    always_comb
    begin
        cond = 1'b0;
        defined = 1'b1;
        case (code_r)
            // Credit stalls, single and aggregate
            ulde_pkg::ULDE_EV_TX_MULTI:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_L0_DRS: cond = l0_stall[0];
                    ulde_pkg::ULDE_UM_L0_NCB: cond = l0_stall[1];
                    ulde_pkg::ULDE_UM_L0_NCS: cond = l0_stall[2];
                    ulde_pkg::ULDE_UM_L1_DRS: cond = l1_stall[0];
                    ulde_pkg::ULDE_UM_L1_NCB: cond = l1_stall[1];
                    ulde_pkg::ULDE_UM_L1_NCS: cond = l1_stall[2];
                    // Aggregates count a cycle once, not once per channel
                    ulde_pkg::ULDE_UM_L0_ALL: cond = |l0_stall;
                    ulde_pkg::ULDE_UM_L1_ALL: cond = |l1_stall;
                    default: defined = 1'b0;
                endcase
            end
            // Header buffer busy, a level
            ulde_pkg::ULDE_EV_HDR_BUSY:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_HDR_L0: cond = link0.hdr_buffer_busy;
                    ulde_pkg::ULDE_UM_HDR_L1: cond = link1.hdr_buffer_busy;
                    default: defined = 1'b0;
                endcase
            end
            // Snoops held by a full tracker
            ulde_pkg::ULDE_EV_SNP_STALL:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_LINK0: cond = l0_snoop_stall;
                    ulde_pkg::ULDE_UM_LINK1: cond = l1_snoop_stall;
                    default: defined = 1'b0;
                endcase
            end
            // Activations opening a page
            ulde_pkg::ULDE_EV_PAGE_OPEN:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_CH0: cond = ch_open[0];
                    ulde_pkg::ULDE_UM_CH1: cond = ch_open[1];
                    ulde_pkg::ULDE_UM_CH2: cond = ch_open[2];
                    default: defined = 1'b0;
                endcase
            end
            // Precharges due to the idle timer
            ulde_pkg::ULDE_EV_IDLE_CLOSE:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_CH0: cond = ch_close[0];
                    ulde_pkg::ULDE_UM_CH1: cond = ch_close[1];
                    ulde_pkg::ULDE_UM_CH2: cond = ch_close[2];
                    default: defined = 1'b0;
                endcase
            end
            // Precharges from a row conflict
            ulde_pkg::ULDE_EV_PAGE_MISS:
            begin
                case (mask_r)
                    ulde_pkg::ULDE_UM_CH0: cond = ch_miss[0];
                    ulde_pkg::ULDE_UM_CH1: cond = ch_miss[1];
                    ulde_pkg::ULDE_UM_CH2: cond = ch_miss[2];
                    default: defined = 1'b0;
                endcase
            end
            // Unknown code never counts
            default: defined = 1'b0;
        endcase
    end

    // Selector next state from software writes
    // Upper write bits are dropped
    always_comb
    begin
        code_nxt = code_r;
        mask_nxt = mask_r;
        if (reg_wr && (reg_addr == ulde_pkg::ULDE_ADDR_SEL))
        begin
            code_nxt = sel_field(reg_wdata, ulde_pkg::ULDE_SEL_CODE_LSB);
            mask_nxt = sel_field(reg_wdata, ulde_pkg::ULDE_SEL_MASK_LSB);
        end
    end

    // Selector registers
    // Reset picks an undefined pair
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            code_r <= ulde_pkg::ULDE_RST_CODE;
            mask_r <= ulde_pkg::ULDE_RST_MASK;
        end
        else
        begin
            code_r <= code_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Increment next value; gated by defined so stray pairs stay silent
    // Costs a cycle of latency, avoids glitches
    always_comb
    begin
        inc_nxt = cond && defined;
        match_nxt = defined;
    end

    // Increment registers: one cycle after the condition, one per cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            inc_r <= 1'b0;
            match_r <= 1'b0;
        end
        else
        begin
            inc_r <= inc_nxt;
            match_r <= match_nxt;
        end
    end

    // Read mux; unmapped addresses and idle cycles read zero
    always_comb
    begin
        rdata_nxt = ulde_pkg::ULDE_RST_RDATA;
        if (reg_rd)
        begin
            case (reg_addr)
                ulde_pkg::ULDE_ADDR_SEL:
                begin
                    rdata_nxt[ulde_pkg::ULDE_SEL_CODE_LSB +: 8] = code_r;
                    rdata_nxt[ulde_pkg::ULDE_SEL_MASK_LSB +: 8] = mask_r;
                end
                ulde_pkg::ULDE_ADDR_STATUS:
                begin
                    // Selection valid and last increment seen
                    rdata_nxt[0] = match_r;
                    rdata_nxt[1] = inc_r;
                end
                ulde_pkg::ULDE_ADDR_COND:
                begin
                    // Live raw conditions, handy when bringing up sources
                    rdata_nxt[2:0] = l0_stall;
                    rdata_nxt[5:3] = l1_stall;
                    rdata_nxt[6] = link0.hdr_buffer_busy;
                    rdata_nxt[7] = link1.hdr_buffer_busy;
                    rdata_nxt[8] = l0_snoop_stall;
                    rdata_nxt[9] = l1_snoop_stall;
                    rdata_nxt[12:10] = ch_open;
                    rdata_nxt[15:13] = ch_close;
                    rdata_nxt[18:16] = ch_miss;
                end
                default: rdata_nxt = ulde_pkg::ULDE_RST_RDATA;
            endcase
        end
    end

    // Read data register: valid in the cycle after the read only
    // Zero between answers, so buses may be ORed
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rdata_r <= ulde_pkg::ULDE_RST_RDATA;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flip-flops
    // No event input reaches a pin unregistered
    assign reg_rdata = rdata_r;
    assign inc = inc_r;

endmodule // ulde_event_select

// ===== ulde_far_side.sv
// Far-side model: link status and DRAM channel schedulers.
// Assumes the bench calls its tasks just after a rising mclk edge.
`timescale 1ns/1ps

module ulde_far_side (
    input wire logic mclk,
    output ulde_pkg::ulde_link_t link0,
    output ulde_pkg::ulde_link_t link1,
    output ulde_pkg::ulde_dram_cmd_t dram_cmd [3]
);
    // Link status for one cycle; w picks the condition
    function automatic ulde_pkg::ulde_link_t mk(input int w);
        ulde_pkg::ulde_link_t l;
        l = '0;
        // Credits present and nothing pending when quiet
        l.data_response_channel = 3'b011;
        l.noncoherent_bypass_channel = 3'b011;
        l.noncoherent_standard_channel = 3'b011;
        case (w)
            0: l.data_response_channel = 3'b100;
            1: l.noncoherent_bypass_channel = 3'b100;
            2: l.noncoherent_standard_channel = 3'b100;
            3: l.hdr_buffer_busy = 1'b1;
            4: {l.snoop_pending, l.peer_probe_tracker_full} = 2'b11;
            5: l.snoop_pending = 1'b1;
            // Pending but shared pool still has credit: not a stall
            6: l.data_response_channel = 3'b110;
            // All three stalled together
            8: {l.data_response_channel, l.noncoherent_bypass_channel,
                l.noncoherent_standard_channel} = 9'h124;
            default: l.hdr_buffer_busy = 1'b0;
        endcase
        return l;
    endfunction

    // Quiet state; idle command fields hold a live-looking precharge
    // so that a missing valid gate shows up
    task automatic idle();
        link0 <= mk(7);
        link1 <= mk(7);
        for (int c = 0; c < 3; c++)
        begin
            dram_cmd[c] <= {1'b0, ulde_pkg::ULDE_CMD_PRE, 3'h2, 16'h0009, 1'b1};
        end
    endtask

    // One link condition, held until idle() is called
    task automatic link(input int ln, input int w);
        if (ln == 0)
            link0 <= mk(w);
        else
            link1 <= mk(w);
    endtask

    // One scheduler command on channel ch
    task automatic cmd(input int ch, input ulde_pkg::ulde_cmd_kind_t k,
                       input logic [2:0] b, input logic [15:0] r, input logic i);
        dram_cmd[ch] <= {1'b1, k, b, r, i};
    endtask

    initial
    begin
        idle();
    end
endmodule // ulde_far_side

// ===== ulde_event_select_chk.sv
// Checker for the event selector, bound onto its ports.
// Tracks the selector from register writes itself.
`timescale 1ns/1ps

module ulde_event_select_chk #(
    parameter int CHANNELS = 3,
    parameter int BANKS = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire ulde_pkg::ulde_link_t link0,
    input wire ulde_pkg::ulde_link_t link1,
    input wire ulde_pkg::ulde_dram_cmd_t dram_cmd [CHANNELS],
    input wire logic inc
);
    logic [15:0] sel_r; // Shadow of mask and code
    logic [15:0] sel_nxt;
    logic [2:0] s0; // Link0 stalls: ncs, ncb, drs
    logic [2:0] s1; // Link1 stalls

    // Stall needs a flit and no credit in either pool
    function automatic logic stl(input ulde_pkg::ulde_vc_t v);
        return v.flit_pending && !v.shared_credit_pool_avail && !v.dedicated_credit_pool_avail;
    endfunction

    assign s0 = {stl(link0.noncoherent_standard_channel),
                 stl(link0.noncoherent_bypass_channel), stl(link0.data_response_channel)};
    assign s1 = {stl(link1.noncoherent_standard_channel),
                 stl(link1.noncoherent_bypass_channel), stl(link1.data_response_channel)};

    // Shadow selector; upper word bits ignored
    always_comb
    begin
        sel_nxt = sel_r;
        if (reg_wr && reg_addr == ulde_pkg::ULDE_ADDR_SEL)
            sel_nxt = reg_wdata[15:0];
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sel_r <= 16'h0000;
        else
            sel_r <= sel_nxt;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_sel_open;
        sel_r == 16'h0160;
    endsequence
    sequence s_act0;
        dram_cmd[0].valid && dram_cmd[0].kind == ulde_pkg::ULDE_CMD_ACT;
    endsequence

    property p_l1_drs; sel_r == 16'h0841 |=> inc == $past(s1[0]); endproperty
    property p_l1_ncb; sel_r == 16'h1041 |=> inc == $past(s1[1]); endproperty
    property p_l1_ncs; sel_r == 16'h2041 && s1[2] |=> inc; endproperty
    property p_l0_any; sel_r == 16'h0741 |=> inc == $past(|s0); endproperty
    property p_l1_any; sel_r == 16'h3841 && !(|s1) |=> !inc; endproperty
    property p_hdr0; sel_r == 16'h0242 |=> inc == $past(link0.hdr_buffer_busy); endproperty
    property p_hdr1; sel_r == 16'h0842 && link1.hdr_buffer_busy |=> inc; endproperty
    property p_snp0;
        sel_r == 16'h0143 |=> inc == $past(link0.snoop_pending && link0.peer_probe_tracker_full);
    endproperty
    property p_l0_drs; sel_r == 16'h0141 && s0[0] |=> inc; endproperty
    property p_open; s_sel_open ##0 s_act0 |=> inc; endproperty
    property p_undef;
        !(sel_r[7:0] inside {8'h41, 8'h42, 8'h43, 8'h60, 8'h61, 8'h62}) || sel_r[15:8] == 8'h00
        |=> !inc;
    endproperty

    a_l1_drs: assert property (p_l1_drs) else $error("link1 data stall miscounted");
    a_l1_ncb: assert property (p_l1_ncb) else $error("link1 bypass stall miscounted");
    a_l1_ncs: assert property (p_l1_ncs) else $error("link1 standard stall lost");
    a_l0_any: assert property (p_l0_any) else $error("link0 aggregate wrong");
    a_l1_any: assert property (p_l1_any) else $error("link1 aggregate false count");
    a_hdr0: assert property (p_hdr0) else $error("link0 header busy wrong");
    a_hdr1: assert property (p_hdr1) else $error("link1 header busy lost");
    a_snp0: assert property (p_snp0) else $error("link0 snoop stall wrong");
    a_l0_drs: assert property (p_l0_drs) else $error("link0 data stall lost");
    a_open: assert property (p_open) else $error("page open lost");
    a_undef: assert property (p_undef) else $error("increment on undefined pair");
endmodule // ulde_event_select_chk

bind ulde_event_select ulde_event_select_chk #(.CHANNELS(CHANNELS), .BANKS(BANKS))
    ulde_event_select_chk_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link0(link0), .link1(link1), .dram_cmd(dram_cmd), .inc(inc));

// ===== ulde_event_select_tb.sv
// Self-checking bench for the event selector.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module ulde_event_select_tb;
    logic mclk;
    logic sys_rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic inc;
    ulde_pkg::ulde_link_t link0;
    ulde_pkg::ulde_link_t link1;
    ulde_pkg::ulde_dram_cmd_t dram_cmd [3];
    int errors = 0;
    int total_checks = 0;
    int cycles = 0; // Hang guard
    logic [31:0] rdv;

    ulde_event_select #(.CHANNELS(3), .BANKS(8)) ulde_event_select_i (.mclk(mclk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link0(link0), .link1(link1),
        .dram_cmd(dram_cmd), .inc(inc));
    ulde_far_side ulde_far_side_i (.mclk(mclk), .link0(link0), .link1(link1),
        .dram_cmd(dram_cmd));

    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %b seen %b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // Bus tasks start and end just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk); // Idle edge between writes
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata; // Data stand only this cycle
        @(posedge mclk);
    endtask

    // Condition held one cycle; increment must follow once, then drop
    task automatic fin(input logic e);
        @(posedge mclk);
        ulde_far_side_i.idle();
        #1 chk_bit("inc", e, inc);
        @(posedge mclk);
        #1 chk_bit("inc after", 1'b0, inc);
        @(posedge mclk);
    endtask

    task automatic ev(input logic [15:0] s, input int ln, input int w, input logic e);
        wr(ulde_pkg::ULDE_ADDR_SEL, {16'h0000, s});
        ulde_far_side_i.link(ln, w);
        fin(e);
    endtask

    task automatic dv(input logic [15:0] s, input int ch, input ulde_pkg::ulde_cmd_kind_t k,
                      input logic [15:0] r, input logic i, input logic e);
        wr(ulde_pkg::ULDE_ADDR_SEL, {16'h0000, s});
        ulde_far_side_i.cmd(ch, k, 3'h2, r, i);
        fin(e);
    endtask

    // Single exit: counts, then verdict
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errors++;
            conclude();
        end
    end

    initial
    begin
        logic [7:0] m;
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        // Selector reset, upper bits ignored, unmapped place inert
        rd(ulde_pkg::ULDE_ADDR_SEL, rdv);
        chk_word("sel reset", 32'h0000_0000, rdv);
        wr(ulde_pkg::ULDE_ADDR_SEL, 32'hffff_0841);
        wr(8'h10, 32'h0000_0243);
        rd(ulde_pkg::ULDE_ADDR_SEL, rdv);
        chk_word("sel", 32'h0000_0841, rdv);
        // Raw conditions and status under a held link1 stall
        ulde_far_side_i.link(1, 0);
        rd(ulde_pkg::ULDE_ADDR_COND, rdv);
        chk_word("cond", 32'h0000_0008, rdv);
        rd(ulde_pkg::ULDE_ADDR_STATUS, rdv);
        chk_word("status", 32'h0000_0003, rdv);
        ulde_far_side_i.idle();
        rd(8'hfc, rdv);
        chk_word("unmapped", 32'h0000_0000, rdv);
        // Link events, hits and near misses
        ev(16'h0841, 1, 0, 1'b1);
        ev(16'h0841, 1, 6, 1'b0);
        ev(16'h1041, 1, 1, 1'b1);
        ev(16'h2041, 1, 2, 1'b1);
        ev(16'h0741, 0, 8, 1'b1);
        ev(16'h0741, 0, 2, 1'b1);
        ev(16'h3841, 1, 1, 1'b1);
        ev(16'h3841, 0, 0, 1'b0);
        ev(16'h0242, 0, 3, 1'b1);
        ev(16'h0842, 1, 3, 1'b1);
        ev(16'h0842, 0, 3, 1'b0);
        ev(16'h0143, 0, 4, 1'b1);
        ev(16'h0143, 0, 5, 1'b0);
        ev(16'h0243, 1, 4, 1'b1);
        ev(16'h0141, 0, 0, 1'b1);
        ev(16'h0241, 0, 0, 1'b0);
        ev(16'h0041, 0, 8, 1'b0);
        ev(16'hff41, 0, 8, 1'b0);
        ev(16'h0140, 0, 0, 1'b0);
        // DRAM events on each channel, bank 2
        for (int c = 0; c < 3; c++)
        begin
            m = 8'h01 << c;
            dv({m, 8'h60}, c, ulde_pkg::ULDE_CMD_ACT, 16'h0005, 1'b0, 1'b1);
            dv({m, 8'h62}, c, ulde_pkg::ULDE_CMD_PRE, 16'h0009, 1'b0, 1'b1);
            dv({m, 8'h62}, c, ulde_pkg::ULDE_CMD_PRE, 16'h0009, 1'b0, 1'b0);
            dv({m, 8'h62}, c, ulde_pkg::ULDE_CMD_ACT, 16'h0009, 1'b0, 1'b0);
            dv({m, 8'h61}, c, ulde_pkg::ULDE_CMD_PRE, 16'h0009, 1'b1, 1'b1);
            dv({8'h01 << ((c + 1) % 3), 8'h60}, c, ulde_pkg::ULDE_CMD_ACT, 16'h0001,
               1'b0, 1'b0);
        end
        conclude();
    end
endmodule // ulde_event_select_tb
